// [design/hssi_baud.sv]
`timescale 1ns/1ps
// counts reference-clock enables down to one bit period
module hssi_baud #(
  parameter int PER_W = hssi_pkg::PER_W
) (
  input wire logic mclk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic ref_en_i, // reference rate enable
  input wire logic [PER_W-1:0] period_i, // bit period in reference cycles
  input wire logic restart_i, // reload the counter
  input wire logic half_i, // reload with half a period
  output logic tick_o // one-cycle pulse per period
);
  logic [PER_W-1:0] cnt_reg;

  if (PER_W < 2)
  begin : g_chk
    $error("hssi_baud: PER_W too small");
  end

  // restart wins over counting so the first period is exact
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (restart_i)
        cnt_reg <= half_i ? (period_i >> 1) : period_i;
      else if (ref_en_i)
      begin
        if (cnt_reg <= PER_W'(1))
        begin
          tick_o <= 1'b1;
          cnt_reg <= period_i;
        end
        else
          cnt_reg <= cnt_reg - PER_W'(1);
      end
    end
  end
endmodule : hssi_baud

// [design/hssi_pkg.sv]
// Overview of operation
// - uart runs at 115.2 kbit/s after reset until reprogrammed.
// - rate is ref/(div+1) if exponent zero, else ref/(div+33)/2^(exp-1).
// - code 7a gives 115.2 kbit/s, 15 gives 1228.8 kbit/s, error under 1.5 percent.
// - uart character is start 0, eight data bits lsb first, stop 1, no parity.
// - uart read is command byte then one returned byte, only while trigger high.
// - uart write is command byte then data byte; command byte echoed back.
// - data byte is accepted even while the echo is still being sent.
// - i2c port is slave only, standard, fast and fast-plus rates.
// - i2c slave never holds the clock line low.
// - general call address ignored; no device identification read.
// - high-speed master code not answered; no high-speed operation.
// - no clock generation and no arbitration in the i2c port.
// - spike filters on clock and data enabled when i2c is selected.
// - data line changes only while clock low, stable while clock high.
// - start is data falling with clock high, stop is data rising with clock high.
// - repeated start handled exactly like start, bus stays busy.
// - i2c bytes msb first, each followed by acknowledge, unlimited count.
// - byte transmitter releases data on ack pulse; receiver holds it low.
// - on master not-acknowledge the slave transmitter releases the data line.
// - slave address is 01010 plus two bits from pins or stored configuration.
// - write frame is address, register pointer, data; pointer advances except fifo.
// - read uses pointer from prior write; successive locations except fifo.
package hssi_pkg;
  localparam logic [7:0] BAUD_RESET = 8'h7a;
  localparam int EXP_MSB = 7;
  localparam int EXP_LSB = 5;
  localparam int DIV_MSB = 4;
  localparam int DIV_LSB = 0;
  localparam int PER_W = 13;
  localparam logic [12:0] DIV_OFS0 = 13'h0001;
  localparam logic [12:0] DIV_OFS1 = 13'h0021;
  localparam logic [7:0] BAUD_ADDR = 8'h3b;
  localparam logic [7:0] FIFO_ADDR = 8'h05;
  localparam logic [4:0] I2C_ADDR_HI = 5'h0a;
  localparam int RW_BIT = 0;
  localparam logic [16:0] REF_KHZ = 17'h069f0;
  localparam logic [16:0] MCLK_KHZ = 17'h09c40;
  localparam int MCLK_PERIOD_NS = 25;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] I2C_BITS = 4'h8;
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_REG = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
endpackage : hssi_pkg

// [design/hssi_top.sv]
`timescale 1ns/1ps
// host serial slave port: uart and i2c register access
module hssi_top #(
  parameter int SPIKE_CYC = hssi_pkg::SPIKE_CYC
) (
  input wire logic mclk_i, // 40 mhz clock
  input wire logic nrst_i, // async reset, active low
  input wire logic if_i2c_i, // 1 selects i2c, 0 selects uart
  input wire logic uart_rx_i, // uart receive line
  output logic uart_tx_o, // uart transmit line
  input wire logic host_pin_three_trigger_i, // read enable trigger
  input wire logic scl_i, // i2c clock input
  input wire logic sda_i, // i2c data input
  output logic sda_o, // i2c data output level
  output logic sda_oe_o, // high while pulling data low
  input wire logic [1:0] adr_sel_i, // address bits from pins
  input wire logic [1:0] adr_cfg_i, // address bits from stored config
  input wire logic adr_use_cfg_i, // 1 takes stored address bits
  output logic [7:0] reg_addr_o, // register address
  output logic [7:0] reg_wdata_o, // register write data
  output logic reg_we_o, // write strobe
  output logic reg_re_o, // read strobe
  input wire logic [7:0] reg_rdata_i, // read data, cycle after strobe
  output logic [7:0] uart_baud_rate_o // baud register contents
);
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } hssi_rx_t;
  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_RECV = 5'b00010,
    I_RACK = 5'b00100,
    I_SEND = 5'b01000,
    I_TACK = 5'b10000
  } hssi_i2c_t;

  logic [16:0] ref_acc_reg;
  logic ref_en_reg;
  logic [7:0] baud_reg;
  logic [7:0] baud_act_reg;
  logic [12:0] period;
  logic rx_tick, tx_tick;
  logic rx_rst_reg, tx_rst_reg;
  hssi_rx_t rx_state_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic rx_done_reg;
  logic tx_busy_reg, tx_load_reg;
  logic [9:0] tx_sh_reg;
  logic [3:0] tx_cnt_reg;
  logic [7:0] tx_byte_reg;
  logic u_phase_reg;
  logic [6:0] u_addr_reg;
  logic [7:0] u_wdata_reg;
  logic u_rd_req_reg, u_wr_req_reg;
  logic rd_req, wr_req;
  logic [7:0] acc_addr, acc_wdata;
  logic [1:0] rd_pipe_reg;
  logic rd_loc_reg, rd_done_reg;
  logic [7:0] rd_data_reg;
  logic [1:0] raw;
  logic [1:0] filt_reg;
  logic scl_q, sda_q, scl_rise, scl_fall, i_start, i_stop;
  hssi_i2c_t i_state_reg;
  logic [3:0] i_cnt_reg;
  logic [7:0] i_sh_reg, i_tsh_reg, i_ptr_reg, i_addr_reg, i_wdata_reg;
  logic [1:0] i_kind_reg;
  logic i_rw_reg, i_rd_req_reg, i_wr_req_reg;

  if (SPIKE_CYC < 1 || SPIKE_CYC > 15)
  begin : g_chk
    $error("hssi_top: SPIKE_CYC out of range");
  end

  // bit period in reference cycles from exponent and divisor
  function automatic logic [12:0] baud_period(input logic [7:0] v);
    logic [12:0] dv;
    dv = 13'(v[hssi_pkg::DIV_MSB:hssi_pkg::DIV_LSB]);
    if (v[hssi_pkg::EXP_MSB:hssi_pkg::EXP_LSB] == 3'h0)
      baud_period = dv + hssi_pkg::DIV_OFS0;
    else
      baud_period = 13'((dv + hssi_pkg::DIV_OFS1) << (v[hssi_pkg::EXP_MSB:hssi_pkg::EXP_LSB] - 3'h1));
  endfunction : baud_period

  // pointer step, held on the fifo location
  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    ptr_step = (p == hssi_pkg::FIFO_ADDR) ? p : p + 8'h01;
  endfunction : ptr_step

  // fractional divider makes 27.12 mhz enables from the 40 mhz clock
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ref_acc_reg <= '0;
      ref_en_reg <= 1'b0;
    end
    else if (ref_acc_reg + hssi_pkg::REF_KHZ >= hssi_pkg::MCLK_KHZ)
    begin
      ref_acc_reg <= ref_acc_reg + hssi_pkg::REF_KHZ - hssi_pkg::MCLK_KHZ;
      ref_en_reg <= 1'b1;
    end
    else
    begin
      ref_acc_reg <= ref_acc_reg + hssi_pkg::REF_KHZ;
      ref_en_reg <= 1'b0;
    end
  end

  // baud register; a new rate takes effect only between characters
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      baud_reg <= hssi_pkg::BAUD_RESET;
      baud_act_reg <= hssi_pkg::BAUD_RESET;
      uart_baud_rate_o <= hssi_pkg::BAUD_RESET;
    end
    else
    begin
      if (wr_req && acc_addr == hssi_pkg::BAUD_ADDR)
        baud_reg <= acc_wdata;
      if (!tx_busy_reg && !tx_load_reg && rx_state_reg == RX_IDLE)
        baud_act_reg <= baud_reg;
      uart_baud_rate_o <= baud_reg;
    end
  end

  assign period = baud_period(baud_act_reg);

  hssi_baud #(
    .PER_W(hssi_pkg::PER_W)
  ) u_rx_baud (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ref_en_i(ref_en_reg),
    .period_i(period),
    .restart_i(rx_rst_reg),
    .half_i(1'b1),
    .tick_o(rx_tick)
  );

  hssi_baud #(
    .PER_W(hssi_pkg::PER_W)
  ) u_tx_baud (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ref_en_i(ref_en_reg),
    .period_i(period),
    .restart_i(tx_rst_reg),
    .half_i(1'b0),
    .tick_o(tx_tick)
  );

  // uart receiver, samples mid-bit after a half-period start check
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_sh_reg <= '0;
      rx_rst_reg <= 1'b0;
      rx_done_reg <= 1'b0;
    end
    else
    begin
      rx_rst_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      unique case (rx_state_reg)
        RX_IDLE:
          if (!if_i2c_i && !uart_rx_i)
          begin
            rx_rst_reg <= 1'b1;
            rx_state_reg <= RX_START;
          end
        RX_START:
          if (rx_tick && !rx_rst_reg)
          begin
            rx_cnt_reg <= '0;
            rx_state_reg <= uart_rx_i ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_tick)
          begin
            rx_sh_reg <= {uart_rx_i, rx_sh_reg[7:1]};
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == hssi_pkg::DATA_LAST[2:0])
              rx_state_reg <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
          begin
            rx_done_reg <= uart_rx_i;
            rx_state_reg <= RX_IDLE;
          end
      endcase
    end
  end

  // uart command handling: read on trigger, write with address echo
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      u_phase_reg <= 1'b0;
      u_addr_reg <= '0;
      u_wdata_reg <= '0;
      u_rd_req_reg <= 1'b0;
      u_wr_req_reg <= 1'b0;
      tx_load_reg <= 1'b0;
      tx_byte_reg <= '0;
    end
    else
    begin
      u_rd_req_reg <= 1'b0;
      u_wr_req_reg <= 1'b0;
      tx_load_reg <= 1'b0;
      if (rd_done_reg && !if_i2c_i)
      begin
        tx_load_reg <= 1'b1;
        tx_byte_reg <= rd_data_reg;
      end
      else if (rx_done_reg && !u_phase_reg)
      begin
        u_addr_reg <= rx_sh_reg[7:1];
        if (rx_sh_reg[hssi_pkg::RW_BIT])
          u_rd_req_reg <= host_pin_three_trigger_i;
        else
        begin
          u_phase_reg <= 1'b1;
          tx_load_reg <= 1'b1;
          tx_byte_reg <= rx_sh_reg;
        end
      end
      else if (rx_done_reg)
      begin
        u_wr_req_reg <= 1'b1;
        u_wdata_reg <= rx_sh_reg;
        u_phase_reg <= 1'b0;
      end
    end
  end

  // uart transmitter: start bit, eight bits lsb first, stop bit
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= '1;
      tx_cnt_reg <= '0;
      tx_rst_reg <= 1'b0;
      uart_tx_o <= 1'b1;
    end
    else
    begin
      tx_rst_reg <= 1'b0;
      if (tx_load_reg && !tx_busy_reg)
      begin
        tx_sh_reg <= {1'b1, tx_byte_reg, 1'b0};
        tx_cnt_reg <= '0;
        tx_busy_reg <= 1'b1;
        tx_rst_reg <= 1'b1;
        uart_tx_o <= 1'b0;
      end
      else if (tx_busy_reg && tx_tick && !tx_rst_reg)
      begin
        if (tx_cnt_reg == hssi_pkg::FRAME_LAST)
        begin
          tx_busy_reg <= 1'b0;
          uart_tx_o <= 1'b1;
        end
        else
        begin
          tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
          uart_tx_o <= tx_sh_reg[1];
          tx_cnt_reg <= tx_cnt_reg + 4'h1;
        end
      end
    end
  end

  // register access port shared by the selected interface
  assign rd_req = if_i2c_i ? i_rd_req_reg : u_rd_req_reg;
  assign wr_req = if_i2c_i ? i_wr_req_reg : u_wr_req_reg;
  assign acc_addr = if_i2c_i ? i_addr_reg : {1'b0, u_addr_reg};
  assign acc_wdata = if_i2c_i ? i_wdata_reg : u_wdata_reg;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reg_addr_o <= '0;
      reg_wdata_o <= '0;
      reg_we_o <= 1'b0;
      reg_re_o <= 1'b0;
      rd_pipe_reg <= '0;
      rd_loc_reg <= 1'b0;
      rd_data_reg <= '0;
      rd_done_reg <= 1'b0;
    end
    else
    begin
      reg_re_o <= rd_req && acc_addr != hssi_pkg::BAUD_ADDR;
      reg_we_o <= wr_req && acc_addr != hssi_pkg::BAUD_ADDR;
      if (rd_req || wr_req)
        reg_addr_o <= acc_addr;
      if (wr_req)
        reg_wdata_o <= acc_wdata;
      if (rd_req)
        rd_loc_reg <= acc_addr == hssi_pkg::BAUD_ADDR;
      rd_pipe_reg <= {rd_pipe_reg[0], rd_req};
      if (rd_pipe_reg[1])
        rd_data_reg <= rd_loc_reg ? baud_reg : reg_rdata_i;
      rd_done_reg <= rd_pipe_reg[1];
    end
  end

  // spike suppression on clock and data while i2c is selected
  assign raw = {sda_i, scl_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    logic [3:0] cnt_reg;
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        filt_reg[g] <= 1'b1;
        cnt_reg <= '0;
      end
      else if (!if_i2c_i || raw[g] == filt_reg[g])
        cnt_reg <= '0;
      else if (cnt_reg == 4'(SPIKE_CYC))
      begin
        filt_reg[g] <= raw[g];
        cnt_reg <= '0;
      end
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // edge and condition detection on the filtered lines
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= filt_reg[0];
      sda_q <= filt_reg[1];
    end
  end

  assign scl_rise = filt_reg[0] && !scl_q;
  assign scl_fall = !filt_reg[0] && scl_q;
  assign i_start = filt_reg[0] && scl_q && sda_q && !filt_reg[1];
  assign i_stop = filt_reg[0] && scl_q && !sda_q && filt_reg[1];

  // i2c slave: only pulls data low, never touches the clock
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      i_state_reg <= I_IDLE;
      i_cnt_reg <= '0;
      i_sh_reg <= '0;
      i_tsh_reg <= '0;
      i_ptr_reg <= '0;
      i_addr_reg <= '0;
      i_wdata_reg <= '0;
      i_kind_reg <= hssi_pkg::KIND_ADDR;
      i_rw_reg <= 1'b0;
      i_rd_req_reg <= 1'b0;
      i_wr_req_reg <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      i_rd_req_reg <= 1'b0;
      i_wr_req_reg <= 1'b0;
      sda_o <= 1'b0; // open drain
      if (!if_i2c_i || i_stop)
      begin
        i_state_reg <= I_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (i_start)
      begin
        i_state_reg <= I_RECV;
        i_cnt_reg <= '0;
        i_kind_reg <= hssi_pkg::KIND_ADDR;
        sda_oe_o <= 1'b0;
      end
      else
        unique case (i_state_reg)
          I_IDLE: ;
          I_RECV:
            if (scl_rise && i_cnt_reg != hssi_pkg::I2C_BITS)
            begin
              i_sh_reg <= {i_sh_reg[6:0], filt_reg[1]};
              i_cnt_reg <= i_cnt_reg + 4'h1;
            end
            else if (scl_fall && i_cnt_reg == hssi_pkg::I2C_BITS)
            begin
              if (i_kind_reg == hssi_pkg::KIND_ADDR)
              begin
                if (i_sh_reg[7:1] == {hssi_pkg::I2C_ADDR_HI, adr_use_cfg_i ? adr_cfg_i : adr_sel_i})
                begin
                  i_rw_reg <= i_sh_reg[hssi_pkg::RW_BIT];
                  sda_oe_o <= 1'b1;
                  i_state_reg <= I_RACK;
                  i_rd_req_reg <= i_sh_reg[hssi_pkg::RW_BIT];
                  i_addr_reg <= i_ptr_reg;
                end
                else
                  i_state_reg <= I_IDLE;
              end
              else if (i_kind_reg == hssi_pkg::KIND_REG)
              begin
                i_ptr_reg <= i_sh_reg;
                sda_oe_o <= 1'b1;
                i_state_reg <= I_RACK;
              end
              else
              begin
                i_wr_req_reg <= 1'b1;
                i_addr_reg <= i_ptr_reg;
                i_wdata_reg <= i_sh_reg;
                i_ptr_reg <= ptr_step(i_ptr_reg);
                sda_oe_o <= 1'b1;
                i_state_reg <= I_RACK;
              end
            end
          I_RACK:
            if (scl_fall)
            begin
              i_cnt_reg <= '0;
              if (i_kind_reg == hssi_pkg::KIND_ADDR && i_rw_reg)
              begin
                i_tsh_reg <= rd_data_reg;
                sda_oe_o <= !rd_data_reg[7];
                i_state_reg <= I_SEND;
              end
              else
              begin
                sda_oe_o <= 1'b0;
                i_kind_reg <= (i_kind_reg == hssi_pkg::KIND_ADDR) ? hssi_pkg::KIND_REG : hssi_pkg::KIND_DATA;
                i_state_reg <= I_RECV;
              end
            end
          I_SEND:
            if (scl_rise)
              i_cnt_reg <= i_cnt_reg + 4'h1;
            else if (scl_fall && i_cnt_reg == hssi_pkg::I2C_BITS)
            begin
              sda_oe_o <= 1'b0;
              i_state_reg <= I_TACK;
            end
            else if (scl_fall)
            begin
              i_tsh_reg <= {i_tsh_reg[6:0], 1'b0};
              sda_oe_o <= !i_tsh_reg[6];
            end
          I_TACK:
            if (scl_rise && filt_reg[1])
              i_state_reg <= I_IDLE;
            else if (scl_rise)
            begin
              i_ptr_reg <= ptr_step(i_ptr_reg);
              i_addr_reg <= ptr_step(i_ptr_reg);
              i_rd_req_reg <= 1'b1;
            end
            else if (scl_fall)
            begin
              i_cnt_reg <= '0;
              i_tsh_reg <= rd_data_reg;
              sda_oe_o <= !rd_data_reg[7];
              i_state_reg <= I_SEND;
            end
        endcase
    end
  end
endmodule : hssi_top

// [dv/hssi_host_model.sv]
`timescale 1ns/1ps
// host controller: uart and i2c master
module hssi_host_model (
  input wire logic mclk_i, // clock
  input wire logic uart_tx_i, // device uart out
  input wire logic sda_oe_i, // device pulls data
  output logic uart_rx_o, // host uart out
  output logic scl_o, // bus clock
  output logic sda_o // resolved data wire
);
  logic sda_m;
  real bitc;
  // pull-up wire, either party pulls low
  assign sda_o = sda_m & ~sda_oe_i;
  initial
  begin
    uart_rx_o = 1'b1;
    scl_o = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : w
  // one bit period, fraction carried on
  task automatic wb(inout real a);
    int n;
    n = $rtoi(a + bitc) - $rtoi(a);
    a = a + bitc;
    w(n);
  endtask : wb
  task automatic uart_put(input logic [7:0] d);
    real a;
    a = 0.0;
    uart_rx_o <= 1'b0;
    wb(a);
    for (int i = 0; i < 8; i++)
    begin
      uart_rx_o <= d[i];
      wb(a);
    end
    uart_rx_o <= 1'b1;
    wb(a);
  endtask : uart_put
  // ok stays low when no character starts
  task automatic uart_get(output logic [7:0] d, output logic ok);
    real a;
    int k;
    a = 0.0;
    k = 0;
    ok = 1'b0;
    d = 8'h00;
    while (uart_tx_i === 1'b1 && k < $rtoi(25.0 * bitc))
    begin
      w(1);
      k++;
    end
    if (uart_tx_i !== 1'b0)
      return;
    w($rtoi(bitc / 2.0));
    for (int i = 0; i < 8; i++)
    begin
      wb(a);
      d[i] = uart_tx_i;
    end
    wb(a);
    ok = uart_tx_i;
  endtask : uart_get
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    w(25);
    scl_o <= 1'b1;
    w(25);
    r = sda_o;
    w(25);
    scl_o <= 1'b0;
    w(25);
  endtask : bit_io
  task automatic i2c_start();
    sda_m <= 1'b1;
    w(25);
    scl_o <= 1'b1;
    w(25);
    sda_m <= 1'b0;
    w(25);
    scl_o <= 1'b0;
    w(25);
  endtask : i2c_start
  task automatic i2c_stop();
    sda_m <= 1'b0;
    w(25);
    scl_o <= 1'b1;
    w(25);
    sda_m <= 1'b1;
    w(25);
  endtask : i2c_stop
  task automatic i2c_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : i2c_wr
  task automatic i2c_rd(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask : i2c_rd
endmodule : hssi_host_model

// [dv/hssi_top_properties.sv]
`timescale 1ns/1ps
// checks port relations of the host serial port
module hssi_top_properties #(
  parameter int SPIKE_CYC = 2
) (
  input wire logic mclk_i, // clock
  input wire logic nrst_i, // reset, low
  input wire logic if_i2c_i, // i2c select
  input wire logic uart_rx_i, // uart in
  input wire logic uart_tx_o, // uart out
  input wire logic host_pin_three_trigger_i, // trigger
  input wire logic scl_i, // bus clock
  input wire logic sda_i, // bus data
  input wire logic sda_o, // data level
  input wire logic sda_oe_o, // data pull
  input wire logic [1:0] adr_sel_i, // pin address
  input wire logic [1:0] adr_cfg_i, // stored address
  input wire logic adr_use_cfg_i, // address pick
  input wire logic [7:0] reg_addr_o, // address
  input wire logic [7:0] reg_wdata_o, // write data
  input wire logic reg_we_o, // write strobe
  input wire logic reg_re_o, // read strobe
  input wire logic [7:0] reg_rdata_i, // read data
  input wire logic [7:0] uart_baud_rate_o // baud
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // rate register, strobes and uart idle line
  a_baud_reset: assert property ($rose(nrst_i) |-> uart_baud_rate_o == 8'h7a)
    else $error("baud not at reset value");
  a_baud_uart: assert property ($changed(uart_baud_rate_o) |-> !if_i2c_i)
    else $error("baud changed in i2c mode");
  a_baud_hidden: assert property (reg_we_o || reg_re_o |-> reg_addr_o != hssi_pkg::BAUD_ADDR)
    else $error("baud address on strobes");
  a_read_pulse: assert property (reg_re_o |=> !reg_re_o && !reg_we_o)
    else $error("read strobe too long");
  a_tx_idle: assert property (if_i2c_i |-> uart_tx_o)
    else $error("uart line not idle");
  // bus data driver
  a_oe_uart: assert property (!if_i2c_i |-> !sda_oe_o)
    else $error("data pulled in uart mode");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data driven high");
  a_drive_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("pull began with clock high");
  a_hold_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("pull changed with clock high");
  a_ack_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("pull dropped early");
  c_write: cover property (reg_we_o);
  c_read: cover property (reg_re_o);
  c_ack: cover property ($rose(sda_oe_o));
  c_baud: cover property ($changed(uart_baud_rate_o));
endmodule : hssi_top_properties

bind hssi_top hssi_top_properties #(.SPIKE_CYC(SPIKE_CYC)) chk (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .if_i2c_i(if_i2c_i), .uart_rx_i(uart_rx_i),
  .uart_tx_o(uart_tx_o), .host_pin_three_trigger_i(host_pin_three_trigger_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .adr_sel_i(adr_sel_i), .adr_cfg_i(adr_cfg_i), .adr_use_cfg_i(adr_use_cfg_i),
  .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o),
  .reg_re_o(reg_re_o), .reg_rdata_i(reg_rdata_i), .uart_baud_rate_o(uart_baud_rate_o)
);

// [dv/test_host_serial_slave_interface.sv]
`timescale 1ns/1ps
// drives both host links, checks register traffic
module test_host_serial_slave_interface;
  logic mclk_i, nrst_i, i2c, trig, use_cfg, rx, tx, scl, sda, sdo, oe, we, re;
  logic [1:0] asel, acfg;
  logic [7:0] addr, wdata, rdata, baud;
  logic [7:0] mem [256];
  logic [7:0] codes [2] = '{8'h3a, 8'h15};
  logic [7:0] bad [5] = '{8'h00, 8'h08, 8'h56, 8'h54, 8'h52};
  int failures, num_checks, cyc;
  hssi_top uut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .if_i2c_i(i2c), .uart_rx_i(rx), .uart_tx_o(tx),
    .host_pin_three_trigger_i(trig), .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(oe),
    .adr_sel_i(asel), .adr_cfg_i(acfg), .adr_use_cfg_i(use_cfg), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_we_o(we), .reg_re_o(re), .reg_rdata_i(rdata),
    .uart_baud_rate_o(baud)
  );
  hssi_host_model host (
    .mclk_i(mclk_i), .uart_tx_i(tx), .sda_oe_i(oe), .uart_rx_o(rx), .scl_o(scl), .sda_o(sda)
  );
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // register store, read data the cycle after the strobe
  always @(posedge mclk_i)
  begin
    if (we === 1'b1)
      mem[addr] <= wdata;
    if (re === 1'b1)
      rdata <= mem[addr];
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
    end
  endtask : chk1
  // bit period in clocks for a rate code
  function automatic real per(input logic [7:0] c);
    int r;
    r = (c[7:5] == 3'h0) ? int'(c[4:0]) + 1 : (int'(c[4:0]) + 33) << (c[7:5] - 3'h1);
    return r * 40.0 / 27.12;
  endfunction : per
  // data byte follows the command at once
  task automatic uwrite(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] e;
    logic k;
    fork
      begin
        host.uart_put({a[6:0], 1'b0});
        host.uart_put(v);
      end
      host.uart_get(e, k);
    join
    chk1(k, 1'b1);
    chk8(e, {a[6:0], 1'b0});
  endtask : uwrite
  task automatic uread(input logic [7:0] a, input logic [7:0] v, input logic x);
    logic [7:0] e;
    logic k;
    fork
      host.uart_put({a[6:0], 1'b1});
      host.uart_get(e, k);
    join
    chk1(k, x);
    if (x)
      chk8(e, v);
  endtask : uread
  task automatic iw(input logic [7:0] v, input logic e);
    logic k;
    host.i2c_wr(v, k);
    chk1(k, e);
  endtask : iw
  task automatic ir(input logic [7:0] v, input logic m);
    logic [7:0] g;
    host.i2c_rd(g, m);
    chk8(g, v);
  endtask : ir
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  initial
  begin
    nrst_i = 1'b0;
    i2c = 1'b0;
    trig = 1'b1;
    asel = 2'h2;
    acfg = 2'h1;
    use_cfg = 1'b0;
    rdata = 8'h00;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h3c;
    host.bitc = per(8'h7a);
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk8(baud, 8'h7a);
    uwrite(8'h12, 8'ha5);
    uread(8'h12, 8'ha5, 1'b1);
    trig <= 1'b0;
    uread(8'h12, 8'h00, 1'b0);
    trig <= 1'b1;
    // program the rate, then read at the new rate
    foreach (codes[k])
    begin
      uwrite(hssi_pkg::BAUD_ADDR, codes[k]);
      repeat (1000) @(posedge mclk_i);
      chk8(baud, codes[k]);
      host.bitc = per(codes[k]);
      uread(8'h41, 8'h41 ^ 8'h3c, 1'b1);
    end
    // write with pointer advance, repeated start, read with increment
    i2c <= 1'b1;
    host.i2c_start();
    iw(8'h54, 1'b1);
    iw(8'h20, 1'b1);
    iw(8'h99, 1'b1);
    host.i2c_start();
    iw(8'h55, 1'b1);
    ir(8'h21 ^ 8'h3c, 1'b1);
    ir(8'h22 ^ 8'h3c, 1'b0);
    host.i2c_stop();
    chk8(mem[32], 8'h99);
    // fifo location keeps the pointer on write and read
    host.i2c_start();
    iw(8'h54, 1'b1);
    iw(8'h05, 1'b1);
    iw(8'h11, 1'b1);
    iw(8'h22, 1'b1);
    host.i2c_start();
    iw(8'h55, 1'b1);
    ir(8'h22, 1'b1);
    ir(8'h22, 1'b0);
    host.i2c_stop();
    // general call, high-speed code, foreign and stored addresses
    for (int k = 0; k < 5; k++)
    begin
      use_cfg <= (k > 2);
      host.i2c_start();
      iw(bad[k], k == 4);
      host.i2c_stop();
    end
    test_done();
  end
endmodule : test_host_serial_slave_interface
